//--- logic/lbp_pkg.sv
// Types and constants of the balanced link procedure engine
package lbp_pkg;
	localparam int         CLK_HZ   = 50000000;
	localparam int         MS_PER_S = 1000;
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_RTO    = 8'h04;
	localparam logic [7:0] A_AHT    = 8'h08;
	localparam logic [7:0] A_MFB    = 8'h0c;
	localparam logic [7:0] A_MRC    = 8'h10;
	localparam logic [7:0] A_K      = 8'h14;
	localparam logic [7:0] A_HQD    = 8'h18;
	localparam logic [7:0] A_STAT   = 8'h1c;
	localparam logic [7:0] A_IST    = 8'h20;
	localparam logic [7:0] A_IMSK   = 8'h24;
	localparam logic [7:0] A_CNT    = 8'h28;
	localparam logic [7:0] A_CEND   = 8'h40;
	localparam int         N_CNT    = 6;
	localparam int         C_EN     = 0;
	localparam int         C_NET    = 1;
	localparam int         C_MULTI  = 2;
	localparam logic [15:0] RTO_RST = 16'h0bb8;
	localparam logic [15:0] AHT_RST = 16'h07d0;
	localparam logic [15:0] MFB_RST = 16'h2ee0;
	localparam logic [7:0]  MRC_RST = 8'h14;
	localparam logic [2:0]  K_RST   = 3'h7;
	localparam logic [2:0]  K_MIN   = 3'h1;
	localparam logic [3:0]  HQ_RST  = 4'h8;
	localparam logic [3:0]  HQ_MIN  = 4'h1;
	localparam int          HQ_N    = 8;
	localparam int          SEQ_N   = 8;
	localparam int I_UP     = 0;
	localparam int I_FAIL   = 1;
	localparam int I_QUENCH = 2;
	localparam int I_DMG    = 3;
	localparam int I_CFG    = 4;
	localparam int I_DROP   = 5;
	localparam int N_IRQ    = 6;
	localparam logic [1:0] P_IP   = 2'h0;
	localparam logic [2:0] NO_CNT = 3'h7;

	typedef enum logic [1:0] {L_DISC, L_SETUP, L_UP} lbpLink_t;
	typedef enum logic [3:0] {F_I, F_RR, F_RNR, F_REJ, F_SABM, F_UA,
		F_DISC, F_DM, F_FRMR} lbpKind_t;
	typedef struct packed {
		logic [1:0]  proto;
		logic [15:0] bits;
	} lbpPkt_t;
	typedef struct packed {
		logic    vld;
		lbpPkt_t p;
	} lbpPktIn_t;
	typedef struct packed {
		lbpKind_t   kind;
		logic [2:0] ns;
		logic [2:0] nr;
		logic       pf;
		lbpPkt_t    p;
	} lbpFrm_t;
	typedef struct packed {
		logic    vld;
		logic    bad;
		lbpFrm_t f;
	} lbpRx_t;
	typedef struct packed {
		lbpLink_t               link;
		logic [2:0]             vs, vr, va, top, hd, tl;
		logic [3:0]             hc;
		logic [7:0]             retry;
		logic [15:0]            t1c, thc, msc;
		logic                   tick, ackP, rejS, busy, uaP, sabmP;
		logic                   pollP, pollW, rejP, fail, qn, up, txv;
		lbpFrm_t                txf;
		lbpPktIn_t              rxo;
		logic [N_CNT-1:0][15:0] ctx, crx;
	} lbpCore_t;

	// Counter slot per frame type; others are not counted
	function automatic logic [2:0] cntIdx(lbpKind_t k);
		case (k)
			F_I:     return 3'h0;
			F_RNR:   return 3'h1;
			F_REJ:   return 3'h2;
			F_SABM:  return 3'h3;
			F_FRMR:  return 3'h4;
			F_DISC:  return 3'h5;
			default: return NO_CNT;
		endcase
	endfunction : cntIdx
endpackage : lbp_pkg

//--- logic/lbp_engine.sv
// Balanced link procedure engine with AHB-Lite register slave
`timescale 1ns/1ps
module lbp_engine #(
	parameter int MS_CYCLES = lbp_pkg::CLK_HZ / lbp_pkg::MS_PER_S
) (
	// Clock and reset
	input  logic               sys_clk,
	input  logic               nrst,
	// AHB-Lite slave
	input  logic               hsel,
	input  logic [31:0]        haddr,
	input  logic [1:0]         htrans,
	input  logic               hwrite,
	input  logic [2:0]         hsize,
	input  logic [31:0]        hwdata,
	input  logic               hready,
	output logic [31:0]        hrdata,
	output logic               hreadyout,
	output logic               hresp,
	// Upper layer
	input  lbp_pkg::lbpPktIn_t pktIn,
	output lbp_pkg::lbpPktIn_t pktOut,
	output logic               quench,
	// Line side
	output lbp_pkg::lbpFrm_t   lnkTx,
	output logic               lnkTxVld,
	input  logic               lnkTxReady,
	input  lbp_pkg::lbpRx_t    lnkRx,
	// Status
	output logic               linkUp,
	output logic               irq
);
	import lbp_pkg::*;

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [2:0]       ctrl_q, ctrl_d;
	logic [15:0]      rto_q, rto_d, aht_q, aht_d, mfb_q, mfb_d;
	logic [7:0]       mrc_q, mrc_d;
	logic [2:0]       k_q, k_d;
	logic [3:0]       hqd_q, hqd_d;
	logic [N_IRQ-1:0] ist_q, ist_d, imsk_q, imsk_d, evt;
	logic             irq_q, irq_d, aW_q, aW_d, rdW_q, rdW_d;
	logic             hrdy_q, hrdy_d, acc, cfgErr;
	logic [7:0]       aA_q, aA_d;
	logic [31:0]      hrdata_q, hrdata_d, rd;
	logic [2:0]       cSel;

	lbpCore_t                core_q, n;
	lbpPkt_t [HQ_N-1:0]      hq_q, hq_d;
	lbpPkt_t [SEQ_N-1:0]     rtx_q, rtx_d;
	logic [2:0]              ci, ct, out;
	logic                    rtoOn, ackDue, push, pop, conn;

	assign hrdata    = hrdata_q;
	assign hreadyout = hrdy_q;
	assign hresp     = 1'b0 & hrdy_q;
	assign pktOut    = core_q.rxo;
	assign quench    = core_q.qn;
	assign lnkTx     = core_q.txf;
	assign lnkTxVld  = core_q.txv;
	assign linkUp    = core_q.up;
	assign irq       = irq_q;

	// Register slave: writes take no wait, reads take one
	always_comb begin
		ctrl_d   = ctrl_q;
		rto_d    = rto_q;
		aht_d    = aht_q;
		mfb_d    = mfb_q;
		mrc_d    = mrc_q;
		k_d      = k_q;
		hqd_d    = hqd_q;
		imsk_d   = imsk_q;
		ist_d    = ist_q;
		hrdata_d = hrdata_q;
		cfgErr   = 1'b0;
		rd       = '0;
		cSel     = 3'((aA_q - A_CNT) >> 2);
		acc      = hsel & hready & htrans[1];
		aW_d     = acc & hwrite;
		aA_d     = acc ? haddr[7:0] : aA_q;
		rdW_d    = acc & ~hwrite;
		hrdy_d   = ~(acc & ~hwrite);
		if (aW_q) begin
			case (aA_q)
				A_CTRL: ctrl_d = hwdata[2:0];
				A_RTO: begin
					if (hwdata[15:0] >= aht_q) rto_d = hwdata[15:0];
					else cfgErr = 1'b1;
				end
				A_AHT: begin
					if (hwdata[15:0] <= rto_q) aht_d = hwdata[15:0];
					else cfgErr = 1'b1;
				end
				A_MFB: begin
					if (hwdata[2:0] == 3'h0 && hwdata[15:0] != 16'h0)
						mfb_d = hwdata[15:0];
					else cfgErr = 1'b1;
				end
				A_MRC: mrc_d = hwdata[7:0];
				A_K: begin
					if (hwdata[2:0] >= K_MIN && hwdata[31:3] == '0)
						k_d = hwdata[2:0];
					else cfgErr = 1'b1;
				end
				A_HQD: begin
					if (hwdata[3:0] >= HQ_MIN && hwdata[3:0] <= HQ_RST
						&& hwdata[31:4] == '0)
						hqd_d = hwdata[3:0];
					else cfgErr = 1'b1;
				end
				A_IST:  ist_d = ist_q & ~hwdata[N_IRQ-1:0];
				A_IMSK: imsk_d = hwdata[N_IRQ-1:0];
				default: ;
			endcase
		end
		// Set after clear, so an event in the clearing cycle survives
		ist_d = ist_d | evt | (N_IRQ'(cfgErr) << I_CFG);
		irq_d = |(ist_d & imsk_d);
		if (rdW_q) begin
			case (aA_q)
				A_CTRL: rd = {29'h0, ctrl_q};
				A_RTO:  rd = {16'h0, rto_q};
				A_AHT:  rd = {16'h0, aht_q};
				A_MFB:  rd = {16'h0, mfb_q};
				A_MRC:  rd = {24'h0, mrc_q};
				A_K:    rd = {29'h0, k_q};
				A_HQD:  rd = {28'h0, hqd_q};
				A_STAT: rd = {4'h0, core_q.hc, core_q.retry, 1'h0,
					core_q.va, 1'h0, core_q.vr, 1'h0, core_q.vs,
					2'h0, core_q.link};
				A_IST:  rd = {26'h0, ist_q};
				A_IMSK: rd = {26'h0, imsk_q};
				default: begin
					if (aA_q >= A_CNT && aA_q < A_CEND)
						rd = {core_q.crx[cSel], core_q.ctx[cSel]};
				end
			endcase
			hrdata_d = rd;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q   <= '0;
			rto_q    <= RTO_RST;
			aht_q    <= AHT_RST;
			mfb_q    <= MFB_RST;
			mrc_q    <= MRC_RST;
			k_q      <= K_RST;
			hqd_q    <= HQ_RST;
			ist_q    <= '0;
			imsk_q   <= '0;
			irq_q    <= 1'b0;
			aW_q     <= 1'b0;
			aA_q     <= '0;
			rdW_q    <= 1'b0;
			hrdy_q   <= 1'b1;
			hrdata_q <= '0;
		end else begin
			ctrl_q   <= ctrl_d;
			rto_q    <= rto_d;
			aht_q    <= aht_d;
			mfb_q    <= mfb_d;
			mrc_q    <= mrc_d;
			k_q      <= k_d;
			hqd_q    <= hqd_d;
			ist_q    <= ist_d;
			imsk_q   <= imsk_d;
			irq_q    <= irq_d;
			aW_q     <= aW_d;
			aA_q     <= aA_d;
			rdW_q    <= rdW_d;
			hrdy_q   <= hrdy_d;
			hrdata_q <= hrdata_d;
		end
	end

	// Link procedure core
	always_comb begin
		n      = core_q;
		hq_d   = hq_q;
		rtx_d  = rtx_q;
		evt    = '0;
		ci     = NO_CNT;
		ct     = NO_CNT;
		push   = 1'b0;
		pop    = 1'b0;
		conn   = 1'b0;
		out    = 3'(core_q.top - core_q.va);
		n.rxo  = '0;
		n.qn   = 1'b0;
		n.tick = core_q.msc == MS_LAST;
		n.msc  = n.tick ? '0 : core_q.msc + 16'h1;
		rtoOn  = core_q.link == L_SETUP
			|| (core_q.link == L_UP && out != 3'h0);
		if (!rtoOn) n.t1c = '0;
		else if (core_q.tick) n.t1c = core_q.t1c + 16'h1;
		if (!core_q.ackP) n.thc = '0;
		else if (core_q.tick) n.thc = core_q.thc + 16'h1;
		ackDue = core_q.ackP && core_q.thc >= aht_q;

		// One frame per accepted slot, responses first
		if (!core_q.txv || lnkTxReady) begin
			n.txv    = 1'b1;
			n.txf    = '0;
			n.txf.nr = core_q.vr;
			if (core_q.uaP) begin
				n.txf.kind = F_UA;
				n.uaP      = 1'b0;
			end else if (core_q.rejP) begin
				n.txf.kind = F_REJ;
				n.rejP     = 1'b0;
				n.rejS     = 1'b1;
				n.ackP     = 1'b0;
			end else if (core_q.sabmP) begin
				n.txf.kind = F_SABM;
				n.txf.pf   = 1'b1;
				n.sabmP    = 1'b0;
			end else if (core_q.pollP) begin
				n.txf.kind = F_RR;
				n.txf.pf   = 1'b1;
				n.pollP    = 1'b0;
				n.pollW    = 1'b1;
			end else if (core_q.link == L_UP && !core_q.busy
				&& core_q.vs != core_q.top) begin
				n.txf.kind = F_I;
				n.txf.ns   = core_q.vs;
				n.txf.p    = rtx_q[core_q.vs];
				n.vs       = core_q.vs + 3'h1;
				n.ackP     = 1'b0;
			end else if (core_q.link == L_UP && !core_q.busy
				&& core_q.hc != 4'h0 && out < k_q) begin
				n.txf.kind          = F_I;
				n.txf.ns            = core_q.top;
				n.txf.p             = hq_q[core_q.hd];
				rtx_d[core_q.top]   = hq_q[core_q.hd];
				n.hd                = core_q.hd + 3'h1;
				pop                 = 1'b1;
				n.top               = core_q.top + 3'h1;
				n.vs                = core_q.top + 3'h1;
				n.ackP              = 1'b0;
			end else if (ackDue) begin
				n.txf.kind = F_RR;
				n.ackP     = 1'b0;
			end else begin
				n.txv = 1'b0;
			end
			if (n.txv) ct = cntIdx(n.txf.kind);
		end

		if (rtoOn && core_q.t1c >= rto_q) begin
			n.t1c   = '0;
			n.retry = core_q.retry + 8'h1;
			if (core_q.retry >= mrc_q) begin
				n.link  = L_DISC;
				n.fail  = 1'b1;
				n.sabmP = 1'b0;
				n.pollP = 1'b0;
				evt[I_FAIL] = 1'b1;
			end else if (core_q.link == L_SETUP) begin
				n.sabmP = 1'b1;
			end else begin
				n.pollP = 1'b1;
			end
		end

		if (lnkRx.vld) begin
			if (lnkRx.bad || lnkRx.f.p.bits > mfb_q) begin
				evt[I_DMG] = 1'b1;
				if (core_q.link == L_UP && !core_q.rejS) n.rejP = 1'b1;
			end else begin
				ci = cntIdx(lnkRx.f.kind);
				case (lnkRx.f.kind)
					F_SABM: begin
						n.uaP = 1'b1;
						conn  = 1'b1;
					end
					F_UA: conn = core_q.link == L_SETUP;
					F_DISC: begin
						n.uaP  = 1'b1;
						n.link = L_DISC;
					end
					F_DM: n.link = L_DISC;
					F_FRMR: begin
						if (core_q.link == L_UP) begin
							n.link  = L_SETUP;
							n.sabmP = 1'b1;
							n.retry = '0;
						end
					end
					F_I, F_RR, F_RNR, F_REJ: begin
						if (core_q.link == L_UP) begin
							if (lnkRx.f.nr != core_q.va) begin
								n.va    = lnkRx.f.nr;
								n.t1c   = '0;
								n.retry = '0;
							end
							if (lnkRx.f.kind != F_I)
								n.busy = lnkRx.f.kind == F_RNR;
							// Go back to the peer's expected frame
							if (lnkRx.f.kind == F_REJ || (lnkRx.f.pf
								&& core_q.pollW && lnkRx.f.kind != F_I)) begin
								n.vs    = lnkRx.f.nr;
								n.pollW = 1'b0;
							end
							if (lnkRx.f.kind == F_I) begin
								if (lnkRx.f.ns == core_q.vr) begin
									n.vr   = core_q.vr + 3'h1;
									n.rxo  = {1'b1, lnkRx.f.p};
									n.rejS = 1'b0;
									n.ackP = 1'b1;
								end else if (!core_q.rejS) begin
									n.rejP = 1'b1;
								end
							end
						end
					end
					default: ;
				endcase
			end
		end
		if (conn) begin
			n.link  = L_UP;
			n.vs    = '0;
			n.vr    = '0;
			n.va    = '0;
			n.top   = '0;
			n.retry = '0;
			n.busy  = 1'b0;
			n.rejS  = 1'b0;
			n.ackP  = 1'b0;
			n.pollW = 1'b0;
			evt[I_UP] = 1'b1;
		end

		// Only the terminal end opens the link on its own
		if (!ctrl_q[C_EN]) begin
			n.link  = L_DISC;
			n.fail  = 1'b0;
			n.sabmP = 1'b0;
			n.pollP = 1'b0;
		end else if (core_q.link == L_DISC && n.link == L_DISC
			&& !ctrl_q[C_NET] && !core_q.fail) begin
			n.link  = L_SETUP;
			n.sabmP = 1'b1;
			n.retry = '0;
		end

		if (pktIn.vld) begin
			if ((!ctrl_q[C_MULTI] && pktIn.p.proto != P_IP)
				|| pktIn.p.bits > mfb_q) begin
				evt[I_DROP] = 1'b1;
			end else if (core_q.hc >= hqd_q) begin
				evt[I_QUENCH] = 1'b1;
				n.qn          = 1'b1;
			end else begin
				hq_d[core_q.tl] = pktIn.p;
				n.tl            = core_q.tl + 3'h1;
				push            = 1'b1;
			end
		end
		n.hc = core_q.hc + {3'h0, push} - {3'h0, pop};
		if (ci != NO_CNT) n.crx[ci] = core_q.crx[ci] + 16'h1;
		if (ct != NO_CNT) n.ctx[ct] = core_q.ctx[ct] + 16'h1;
		n.up = n.link == L_UP;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			core_q <= '0;
			hq_q   <= '0;
			rtx_q  <= '0;
		end else begin
			core_q <= n;
			hq_q   <= hq_d;
			rtx_q  <= rtx_d;
		end
	end
endmodule : lbp_engine

//--- sim/lbp_engine_sva.sv
// Port checker of the link engine
`timescale 1ns/1ps
module lbp_engine_sva
	import lbp_pkg::*;
(
	// Clock and reset
	input logic               sys_clk,
	input logic               nrst,
	// Bus
	input logic               hsel,
	input logic [1:0]         htrans,
	input logic               hwrite,
	input logic               hready,
	input logic               hreadyout,
	input logic               hresp,
	// Upper layer
	input lbp_pkg::lbpPktIn_t pktIn,
	input lbp_pkg::lbpPktIn_t pktOut,
	input logic               quench,
	// Line
	input lbp_pkg::lbpFrm_t   lnkTx,
	input logic               lnkTxVld,
	input logic               lnkTxReady,
	input lbp_pkg::lbpRx_t    lnkRx,
	input logic               linkUp
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	AST_OKAY: assert property (!hresp) else $error("response not okay");
	AST_QUENCH_SRC: assert property (quench |-> $past(pktIn.vld))
		else $error("quench without offer");
	AST_SUP_NS: assert property (lnkTxVld && lnkTx.kind inside
		{F_RR, F_RNR, F_REJ} |-> lnkTx.ns == 3'h0) else $error("ns set");
	AST_I_UP: assert property ($rose(lnkTxVld) && lnkTx.kind == F_I
		|-> linkUp) else $error("data while down");
	AST_DMG_REJ: assert property (linkUp && lnkRx.vld && lnkRx.bad
		|-> ##[1:40] lnkTxVld && lnkTx.kind == F_REJ) else $error("no reject");
	AST_DELIVER: assert property (pktOut.vld |-> $past(lnkRx.vld)
		&& $past(lnkRx.f.kind) == F_I && !$past(lnkRx.bad)
		&& pktOut.p == $past(lnkRx.f.p)) else $error("bad delivery");
	AST_UP_CAUSE: assert property ($rose(linkUp) |-> $past(lnkRx.vld)
		&& $past(lnkRx.f.kind) inside {F_UA, F_SABM}) else $error("bad up");
	AST_TX_HOLD: assert property (lnkTxVld && !lnkTxReady
		|=> lnkTxVld && $stable(lnkTx)) else $error("frame dropped");
endmodule : lbp_engine_sva

bind lbp_engine lbp_engine_sva u_sva (.sys_clk, .nrst, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .pktIn, .pktOut, .quench,
	.lnkTx, .lnkTxVld, .lnkTxReady, .lnkRx, .linkUp);

//--- sim/lbp_peer.sv
// Peer station on the far side of the line
`timescale 1ns/1ps
module lbp_peer
	import lbp_pkg::*;
(
	// Clock and reset
	input  logic             sys_clk,
	input  logic             nrst,
	// Bench control
	input  logic             stall,
	input  logic             mute,
	input  lbp_pkg::lbpRx_t  inj,
	// Line
	input  lbp_pkg::lbpFrm_t lnkTx,
	input  logic             lnkTxVld,
	output logic             lnkTxReady,
	output lbp_pkg::lbpRx_t  lnkRx
);
	lbpFrm_t    rsp[$];
	lbpRx_t     nx;
	logic [2:0] vr;
	logic       inSeq;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			lnkTxReady <= 1'b0;
			lnkRx      <= '0;
			vr         <= 3'h0;
			rsp.delete();
		end else begin
			// Random stalls so the engine never sees a prompt line only
			lnkTxReady <= !stall && ($urandom % 4 != 0);
			inSeq = lnkTx.ns == vr;
			if (lnkTxVld && lnkTxReady && !mute) begin
				case (lnkTx.kind)
					F_SABM, F_DISC:
						rsp.push_back('{F_UA, 3'h0, 3'h0, lnkTx.pf, '0});
					F_I: begin
						vr <= vr + 3'(inSeq);
						rsp.push_back('{F_RR, 3'h0, vr + 3'(inSeq), 1'b0, '0});
					end
					F_RR: if (lnkTx.pf)
						rsp.push_back('{F_RR, 3'h0, vr, 1'b1, '0});
					default: ;
				endcase
			end
			// Idle line shows garbage, never the last frame
			nx = '{1'b0, 1'b0, ~lnkRx.f};
			if (inj.vld) begin
				nx = inj;
				nx.f.nr = vr;
			end else if (rsp.size() != 0)
				nx = '{1'b1, 1'b0, rsp.pop_front()};
			lnkRx <= nx;
		end
	end
endmodule : lbp_peer

//--- sim/tb_lbp_engine.sv
// Self-checking bench of the link engine
`timescale 1ns/1ps
module tb_lbp_engine;
	import lbp_pkg::*;
	logic        sys_clk, nrst, hsel, hwrite, rdPh, stall, mute;
	logic        hreadyout, hresp, quench, lnkTxVld, lnkTxReady;
	logic        linkUp, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	lbpPktIn_t   pktIn, pktOut;
	lbpFrm_t     lnkTx;
	lbpRx_t      lnkRx, inj;
	logic [31:0] expQ[$];
	logic [17:0] outQ[$];
	int          failures = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          nq = 0;
	logic [7:0]  ra[8] = '{A_CTRL, A_RTO, A_AHT, A_MFB, A_MRC, A_K, A_HQD,
		8'h80};
	logic [31:0] rv[8] = '{32'h0, 32'h0bb8, 32'h07d0, 32'h2ee0, 32'h14,
		32'h7, 32'h8, 32'h0};

	lbp_engine #(.MS_CYCLES(10)) dut_u (.sys_clk, .nrst, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .pktIn, .pktOut, .quench, .lnkTx, .lnkTxVld,
		.lnkTxReady, .lnkRx, .linkUp, .irq);
	lbp_peer peer_u (.sys_clk, .nrst, .stall, .mute, .inj, .lnkTx,
		.lnkTxVld, .lnkTxReady, .lnkRx);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chkW(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chkW

	task automatic chkP(input logic [17:0] g, input logic [17:0] e);
		chkW({14'h0, g}, {14'h0, e});
	endtask : chkP

	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk iff hreadyout);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdPh   <= !w;
		@(posedge sys_clk iff hreadyout);
		rdPh   <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		xfer(a, 1'b0, 32'h0);
	endtask : rd

	task automatic ist(input logic [31:0] e);
		rd(A_IST, e);
		xfer(A_IST, 1'b1, 32'h3f);
	endtask : ist

	task automatic flag(ref logic s, input logic e);
		repeat (4) @(negedge sys_clk);
		chkW({31'h0, s}, {31'h0, e});
	endtask : flag

	task automatic send(input logic [1:0] pr, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			pktIn <= {1'b1, pr, 16'($urandom % 12000)};
		end
		@(posedge sys_clk);
		pktIn.vld <= 1'b0;
	endtask : send

	task automatic rx(input logic bad, input logic [2:0] ns,
		input logic [1:0] pr);
		logic [17:0] p;
		p = {pr, 16'($urandom % 12000)};
		if (!bad)
			outQ.push_back(p);
		@(posedge sys_clk);
		inj <= {1'b1, bad, F_I, ns, 3'h0, 1'b0, p};
		@(posedge sys_clk);
		inj.vld <= 1'b0;
		repeat (30) @(posedge sys_clk);
	endtask : rx

	// Supervisory or unnumbered frame from the peer
	task automatic ctl(input lbpKind_t k);
		@(posedge sys_clk);
		inj <= {1'b1, 1'b0, k, 3'h0, 3'h0, 1'b0, 18'h0};
		@(posedge sys_clk);
		inj.vld <= 1'b0;
		repeat (30) @(posedge sys_clk);
	endtask : ctl

	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	always @(posedge sys_clk) begin
		if (rdPh && hreadyout)
			chkW(hrdata, expQ.pop_front());
		if (pktOut.vld)
			chkP(pktOut.p, outQ.size() != 0 ? outQ.pop_front() : 18'hx);
		nq <= nq + int'(quench);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		{nrst, hsel, hwrite, rdPh, stall, mute} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		pktIn = '0;
		inj = '0;
		void'($urandom(56069));
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		note("reset");
		xfer(A_AHT, 1'b1, 32'h0bb9);
		xfer(A_MFB, 1'b1, 32'h2ee4);
		xfer(A_K, 1'b1, 32'h8);
		xfer(A_K, 1'b1, 32'h0);
		rd(A_AHT, 32'h07d0);
		rd(A_MFB, 32'h2ee0);
		rd(A_K, 32'h7);
		flag(irq, 1'b0);
		xfer(A_IMSK, 1'b1, 32'h10);
		flag(irq, 1'b1);
		ist(32'h10);
		flag(irq, 1'b0);
		xfer(A_K, 1'b1, 32'h3);
		rd(A_K, 32'h3);
		note("config");
		xfer(A_AHT, 1'b1, 32'h0);
		xfer(A_RTO, 1'b1, 32'h14);
		rd(A_RTO, 32'h14);
		xfer(A_CTRL, 1'b1, 32'h1);
		for (int i = 0; i < 300 && linkUp !== 1'b1; i++) @(posedge sys_clk);
		chkW({31'h0, linkUp}, 32'h1);
		rd(A_CNT + 8'h0c, 32'h1);
		rd(A_STAT, 32'h2);
		ist(32'h1);
		note("link up");
		send(2'h0, 4);
		rx(1'b0, 3'h0, 2'h0);
		rx(1'b0, 3'h1, 2'h0);
		rx(1'b1, 3'h2, 2'h0);
		rx(1'b0, 3'h2, 2'h0);
		rd(A_CNT, 32'h00030004);
		rd(A_CNT + 8'h08, 32'h1);
		ist(32'h8);
		note("traffic");
		send(2'h1, 1);
		ist(32'h20);
		xfer(A_CTRL, 1'b1, 32'h5);
		send(2'h1, 1);
		rx(1'b0, 3'h3, 2'h2);
		rd(A_CNT, 32'h00040005);
		note("protocols");
		xfer(A_HQD, 1'b1, 32'h1);
		stall <= 1'b1;
		send(2'h0, 4);
		ist(32'h4);
		stall <= 1'b0;
		chkW(32'(nq != 0), 32'h1);
		repeat (100) @(posedge sys_clk);
		note("overflow");
		xfer(A_MRC, 1'b1, 32'h2);
		mute <= 1'b1;
		send(2'h0, 1);
		for (int i = 0; i < 3000 && linkUp !== 1'b0; i++) @(posedge sys_clk);
		chkW({31'h0, linkUp}, 32'h0);
		ist(32'h2);
		note("failure");
		xfer(A_CTRL, 1'b1, 32'h0);
		mute <= 1'b0;
		xfer(A_CTRL, 1'b1, 32'h3);
		// Network end must wait for the peer to open
		repeat (300) @(posedge sys_clk);
		chkW({31'h0, linkUp}, 32'h0);
		ctl(F_SABM);
		chkW({31'h0, linkUp}, 32'h1);
		rd(A_CNT + 8'h0c, 32'h00010001);
		ctl(F_DISC);
		chkW({31'h0, linkUp}, 32'h0);
		rd(A_CNT + 8'h14, 32'h00010000);
		note("network role");
		close_out();
	end
endmodule : tb_lbp_engine
